// [hw/mpm_core.v]
// Four-phase dual-output PWM phase manager with APB registers
// ****************************************************************
// Summary of operation
// - Eight stored configurations, strap selects one
// - Supports 4+0, 3+1, 2+2 and fewer
// - Any phase may belong to either output
// - Constant frequency, independent leading/trailing edges
// - Pulse insert, average frequency limited
// - Switching frequency programmable 200 kHz to 1 MHz
// - Optional auto drop driven only by load
// - Drop order: output 1 lowest, else highest
// - Drop one phase per programmed delay
// - Large error re-adds all phases at once
// - Add/drop current thresholds are programmable
// - Dropped phases get periodic boot refresh pulses
// - PMBus updates setpoint and margins while running
// - Targets clamped to configured max and min
// - AVSBus path also updates output target
// - Address strap decoded to sixteen bus addresses
// - Output 0 sensed current corrected for sense temperature
// ****************************************************************
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "mpm_map.vh"
module mpm_core #(
    parameter NPH = 4,
    parameter NCFG = 8
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [2:0]  config_strap,
    input  wire [3:0]  address_strap,
    input  wire        pulse_insert,
    output reg  [3:0]  pwm_high,
    output reg  [3:0]  pwm_low,
    output reg  [6:0]  bus_address
);
    // ****************************************************************
    // Address decode and voltage clamp helpers
    // ****************************************************************
    function [6:0] addr_bin;
        input [3:0] b;
        begin
            case (b)
                4'h0: addr_bin = 7'h60;
                4'h1: addr_bin = 7'h63;
                4'h2: addr_bin = 7'h66;
                4'h3: addr_bin = 7'h67;
                4'h4: addr_bin = 7'h42;
                4'h5: addr_bin = 7'h43;
                4'h6: addr_bin = 7'h46;
                4'h7: addr_bin = 7'h47;
                4'h8: addr_bin = 7'h52;
                4'h9: addr_bin = 7'h53;
                4'ha: addr_bin = 7'h56;
                4'hb: addr_bin = 7'h57;
                4'hc: addr_bin = 7'h5a;
                4'hd: addr_bin = 7'h5b;
                4'he: addr_bin = 7'h5e;
                default: addr_bin = 7'h5f;
            endcase
        end
    endfunction
    // Clamp a voltage code between the output's minimum and maximum
    function [15:0] clamp;
        input [15:0] v;
        input [31:0] lim;
        begin
            clamp = (v > lim[31:16]) ? lim[31:16] : ((v < lim[15:0]) ? lim[15:0] : v);
        end
    endfunction
    // ****************************************************************
    // Strap and pulse insert synchronisers
    // ****************************************************************
    reg [2:0] cfg_s1, cfg_s2;
    reg [3:0] adr_s1, adr_s2;
    reg       ins_s1, ins_s2;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_s1 <= 3'h0;
            cfg_s2 <= 3'h0;
            adr_s1 <= 4'h0;
            adr_s2 <= 4'h0;
            ins_s1 <= 1'b0;
            ins_s2 <= 1'b0;
        end else begin
            cfg_s1 <= config_strap;
            cfg_s2 <= cfg_s1;
            adr_s1 <= address_strap;
            adr_s2 <= adr_s1;
            ins_s1 <= pulse_insert;
            ins_s2 <= ins_s1;
        end
    end
    // ****************************************************************
    // Registers
    // ****************************************************************
    reg        run, autodrop;
    reg [3:0]  owner;
    reg [15:0] period;
    reg [31:0] duty0, duty1;
    reg [15:0] iload0, iload1;
    reg [31:0] thresh;
    reg [23:0] dropdly, refresh;
    reg [15:0] errfast, err_now;
    reg [31:0] vlim0, vlim1;
    reg [15:0] vt [0:5];
    reg [15:0] tcomp, icorr;
    reg [15:0] nv_period [0:NCFG-1];
    wire       wr = psel & penable & pwrite;
    wire       known = (paddr <= `MPM_A_ICORR) && (paddr[1:0] == 2'b00);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~known;
    wire [2:0] vsel = {pwdata[`MPM_VREQ_KIND+1:`MPM_VREQ_KIND], pwdata[`MPM_VREQ_OUT]} > 3'h5
                      ? 3'h0 : {pwdata[`MPM_VREQ_KIND+1:`MPM_VREQ_KIND], pwdata[`MPM_VREQ_OUT]};
    wire [31:0] vlim_sel = pwdata[`MPM_VREQ_OUT] ? vlim1 : vlim0;
    wire [15:0] per_in = (pwdata[15:0] < `MPM_PERIOD_MIN) ? `MPM_PERIOD_MIN :
                         ((pwdata[15:0] > `MPM_PERIOD_MAX) ? `MPM_PERIOD_MAX : pwdata[15:0]);
    integer k;
    // Writes; stored sets are loaded on a write with the run bit low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
            autodrop <= 1'b0;
            owner <= `MPM_RST_OWNER;
            period <= `MPM_RST_PERIOD;
            duty0 <= 32'h0;
            duty1 <= 32'h0;
            iload0 <= 16'h0;
            iload1 <= 16'h0;
            thresh <= 32'h0;
            dropdly <= `MPM_RST_DROPDLY;
            refresh <= `MPM_RST_REFRESH;
            errfast <= 16'hffff;
            err_now <= 16'h0;
            vlim0 <= 32'hffff0000;
            vlim1 <= 32'hffff0000;
            tcomp <= 16'h0;
            for (k = 0; k < 6; k = k + 1)
                vt[k] <= 16'h0;
            for (k = 0; k < NCFG; k = k + 1)
                nv_period[k] <= `MPM_RST_PERIOD;
        end else if (wr) begin
            case (paddr)
                `MPM_A_CTRL: begin
                    run <= pwdata[`MPM_CTRL_RUN];
                    autodrop <= pwdata[`MPM_CTRL_AUTODROP];
                    if (!pwdata[`MPM_CTRL_RUN])
                        period <= nv_period[cfg_s2];
                end
                `MPM_A_OWNER: owner <= pwdata[3:0];
                `MPM_A_PERIOD: begin
                    period <= per_in;
                    nv_period[pwdata[18:16]] <= per_in;
                end
                `MPM_A_DUTY0: duty0 <= pwdata;
                `MPM_A_DUTY1: duty1 <= pwdata;
                `MPM_A_ILOAD0: iload0 <= pwdata[15:0];
                `MPM_A_ILOAD1: iload1 <= pwdata[15:0];
                `MPM_A_THRESH: thresh <= pwdata;
                `MPM_A_DROPDLY: dropdly <= pwdata[23:0];
                `MPM_A_REFRESH: refresh <= pwdata[23:0];
                `MPM_A_ERRFAST: begin
                    errfast <= pwdata[31:16];
                    err_now <= pwdata[15:0];
                end
                `MPM_A_VLIMIT0: vlim0 <= pwdata;
                `MPM_A_VLIMIT1: vlim1 <= pwdata;
                `MPM_A_VREQ: vt[vsel] <= clamp(pwdata[15:0], vlim_sel);
                `MPM_A_TEMPCOMP: tcomp <= pwdata[15:0];
                default: ;
            endcase
        end
    end
    // Temperature-corrected current: i * (1 + tcomp/65536), registered with the outputs
    wire [31:0] icorr_prod = iload0 * tcomp;
    // ****************************************************************
    // Phase drop and add sequencing
    // ****************************************************************
    reg [3:0]  active;
    reg [23:0] dcnt;
    // Load needs: one phase per threshold step crossed, at least one unless the output owns none
    function [2:0] need;
        input [15:0] i;
        input [15:0] step;
        input [2:0]  avail;
        begin
            if (avail == 3'h0)
                need = 3'h0;
            else if (step == 16'h0 || i >= {step[13:0], 2'b00})
                need = avail;
            else if (i >= {step[14:0], 1'b0} + step)
                need = (avail > 3'h3) ? 3'h3 : avail;
            else if (i >= {step[14:0], 1'b0})
                need = (avail > 3'h2) ? 3'h2 : avail;
            else
                need = 3'h1;
        end
    endfunction
    function [2:0] popc;
        input [3:0] m;
        begin
            popc = {2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]} + {2'b00, m[3]};
        end
    endfunction
    wire [2:0] n0 = popc(~owner & active);
    wire [2:0] n1 = popc(owner & active);
    wire [2:0] r0 = autodrop ? need(iload0, thresh[15:0], popc(~owner)) : popc(~owner);
    wire [2:0] r1 = autodrop ? need(iload1, thresh[31:16], popc(owner)) : popc(owner);
    reg  [3:0] drop_bit, add_bit;
    integer j, ph;
    // Pick victim: output 1 lowest active, output 0 highest; re-add is the reverse
    always @* begin
        drop_bit = 4'h0;
        add_bit  = 4'h0;
        if (n1 > r1) begin
            for (j = 3; j >= 0; j = j - 1)
                if (owner[j] && active[j])
                    drop_bit = 4'h1 << j;
        end else if (n0 > r0) begin
            for (j = 0; j < 4; j = j + 1)
                if (!owner[j] && active[j])
                    drop_bit = 4'h1 << j;
        end
        if (n1 < r1) begin
            for (j = 0; j < 4; j = j + 1)
                if (owner[j] && !active[j])
                    add_bit = 4'h1 << j;
        end else if (n0 < r0) begin
            for (j = 3; j >= 0; j = j - 1)
                if (!owner[j] && !active[j])
                    add_bit = 4'h1 << j;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= 4'hf;
            dcnt <= 24'h0;
        end else if (!run || err_now > errfast) begin
            active <= 4'hf;
            dcnt <= 24'h0;
        end else if (add_bit != 4'h0) begin
            active <= active | add_bit;
            dcnt <= 24'h0;
        end else if (drop_bit == 4'h0) begin
            dcnt <= 24'h0;
        end else if (dcnt >= dropdly) begin
            active <= active & ~drop_bit;
            dcnt <= 24'h0;
        end else begin
            dcnt <= dcnt + 24'h1;
        end
    end
    // ****************************************************************
    // Dual-edge modulator with refresh for dropped phases
    // ****************************************************************
    reg [15:0] pcnt;
    reg [23:0] rcnt;
    reg        ins_used;
    wire [15:0] ph_off = {2'b00, period[15:2]};
    reg  [15:0] pos;
    reg  [31:0] dty;
    reg  [3:0]  next_high, next_low;
    always @* begin
        next_high = 4'h0;
        next_low  = 4'h0;
        pos = 16'h0;
        dty = 32'h0;
        for (ph = 0; ph < NPH; ph = ph + 1) begin
            pos = pcnt + ph_off * ph[15:0];
            if (pos >= period)
                pos = pos - period;
            dty = owner[ph] ? duty1 : duty0;
            if (run && active[ph]) begin
                next_high[ph] = (pos >= dty[15:0] && pos < dty[31:16]) ||
                                (ins_s2 && !ins_used);
                next_low[ph] = !next_high[ph];
            end else if (run) begin
                next_low[ph] = (rcnt < {16'h0, `MPM_REFRESH_LEN});
            end
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt <= 16'h0;
            rcnt <= 24'h0;
            ins_used <= 1'b0;
            pwm_high <= 4'h0;
            pwm_low <= 4'h0;
            bus_address <= 7'h60;
            icorr <= 16'h0;
        end else begin
            pcnt <= (pcnt + 16'h1 >= period) ? 16'h0 : pcnt + 16'h1;
            rcnt <= (rcnt >= refresh) ? 24'h0 : rcnt + 24'h1;
            ins_used <= (pcnt != 16'h0) && (ins_used || ins_s2); // One insert per period
            pwm_high <= next_high;
            pwm_low <= next_low;
            bus_address <= addr_bin(adr_s2);
            icorr <= iload0 + icorr_prod[31:16];
        end
    end
    // ****************************************************************
    // Read path
    // ****************************************************************
    always @* begin
        case (paddr)
            `MPM_A_CTRL: prdata = {25'h0, cfg_s2, 2'b00, autodrop, run};
            `MPM_A_OWNER: prdata = {28'h0, owner};
            `MPM_A_PERIOD: prdata = {16'h0, period};
            `MPM_A_DUTY0: prdata = duty0;
            `MPM_A_DUTY1: prdata = duty1;
            `MPM_A_ILOAD0: prdata = {16'h0, iload0};
            `MPM_A_ILOAD1: prdata = {16'h0, iload1};
            `MPM_A_THRESH: prdata = thresh;
            `MPM_A_DROPDLY: prdata = {8'h0, dropdly};
            `MPM_A_REFRESH: prdata = {8'h0, refresh};
            `MPM_A_ERRFAST: prdata = {errfast, err_now};
            `MPM_A_VLIMIT0: prdata = vlim0;
            `MPM_A_VLIMIT1: prdata = vlim1;
            `MPM_A_VTARGET: prdata = {vt[1], vt[0]};
            `MPM_A_STATUS: prdata = {9'h0, bus_address, 12'h0, active};
            `MPM_A_TEMPCOMP: prdata = {16'h0, tcomp};
            `MPM_A_ICORR: prdata = {16'h0, icorr};
            default: prdata = 32'h0;
        endcase
    end
endmodule

// [hw/mpm_map.vh]
// Register map, field layout, reset values and timing constants of the phase manager
`ifndef MPM_MAP_VH
`define MPM_MAP_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MPM_A_CTRL      8'h00
`define MPM_A_OWNER     8'h04
`define MPM_A_PERIOD    8'h08
`define MPM_A_DUTY0     8'h0c
`define MPM_A_DUTY1     8'h10
`define MPM_A_ILOAD0    8'h14
`define MPM_A_ILOAD1    8'h18
`define MPM_A_THRESH    8'h1c
`define MPM_A_DROPDLY   8'h20
`define MPM_A_REFRESH   8'h24
`define MPM_A_ERRFAST   8'h28
`define MPM_A_VLIMIT0   8'h2c
`define MPM_A_VLIMIT1   8'h30
`define MPM_A_VREQ      8'h34
`define MPM_A_VTARGET   8'h38
`define MPM_A_STATUS    8'h3c
`define MPM_A_TEMPCOMP  8'h40
`define MPM_A_ICORR     8'h44
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define MPM_CTRL_RUN      0
`define MPM_CTRL_AUTODROP 1
`define MPM_CTRL_CFGSEL   4
`define MPM_VREQ_OUT      16
`define MPM_VREQ_KIND     17
`define MPM_VREQ_AVS      19
`define MPM_KIND_CMD      2'h0
`define MPM_KIND_MHIGH    2'h1
`define MPM_KIND_MLOW     2'h2
`define MPM_RST_OWNER     4'hc
`define MPM_RST_PERIOD    16'h0014
`define MPM_RST_DROPDLY   24'h002710
`define MPM_RST_REFRESH   24'h0003e8
// ****************************************************************
// Timing: 10 MHz pclk; period counts for 1 MHz and 200 kHz limits
// ****************************************************************
`define MPM_PERIOD_MIN    16'h000a
`define MPM_PERIOD_MAX    16'h0032
`define MPM_REFRESH_LEN   8'h04
`endif

// [tb/mpm_core_props.sv]
// Port-level concurrent checks for the phase manager core
`timescale 1ns/1ps
module mpm_core_props #(
    parameter NPH  = 4,
    parameter NCFG = 8
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  config_strap,
    input wire logic [3:0]  address_strap,
    input wire logic        pulse_insert,
    input wire logic [3:0]  pwm_high,
    input wire logic [3:0]  pwm_low,
    input wire logic [6:0]  bus_address
);
    // Bin 0 in the low byte; only seven bits of each byte are an address
    localparam logic [127:0] ADDR_TAB = {8'h5f, 8'h5e, 8'h5b, 8'h5a, 8'h57, 8'h56, 8'h53, 8'h52,
                                         8'h47, 8'h46, 8'h43, 8'h42, 8'h67, 8'h66, 8'h63, 8'h60};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************************************
    // Bus answers
    // ****************************************************************
    ready_high_a: assert property (psel |-> pready) else $error("pready low");
    unmap_err_a: assert property (psel && penable && paddr > 8'h44 |-> pslverr)
        else $error("no error on unmapped access");
    mapped_ok_a: assert property (psel && penable && paddr <= 8'h44 && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("error on mapped access");
    unmap_zero_a: assert property (psel && penable && !pwrite && paddr > 8'h44
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    // ****************************************************************
    // Power stage and strap outputs
    // ****************************************************************
    // Both switches on in one phase would short the input rail
    no_shoot_a: assert property ((pwm_high & pwm_low) == 4'h0) else $error("shoot-through");
    reset_quiet_a: assert property ($rose(presetn) |-> pwm_high == 4'h0 && pwm_low == 4'h0
        && bus_address == 7'h60) else $error("outputs not quiet out of reset");
    addr_table_a: assert property (bus_address inside {7'h60, 7'h63, 7'h66, 7'h67, 7'h42,
        7'h43, 7'h46, 7'h47, 7'h52, 7'h53, 7'h56, 7'h57, 7'h5a, 7'h5b, 7'h5e, 7'h5f})
        else $error("address outside table");
    // Five stable samples cover the two sync flops and the output register
    addr_follow_a: assert property ($stable(address_strap) [*5]
        |-> bus_address == ADDR_TAB[address_strap * 8 +: 7]) else $error("strap decode wrong");
endmodule
bind mpm_core mpm_core_props #(.NPH(NPH), .NCFG(NCFG)) i_mpm_core_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_strap(config_strap), .address_strap(address_strap), .pulse_insert(pulse_insert),
    .pwm_high(pwm_high), .pwm_low(pwm_low), .bus_address(bus_address));

// [tb/mpm_core_tb_top.sv]
// Self-checking testbench of the phase manager core
`timescale 1ns/1ps
`include "mpm_map.vh"
module mpm_core_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pulse_insert, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  config_strap;
    logic [3:0]  address_strap, pwm_high, pwm_low;
    logic [6:0]  bus_address;
    logic [15:0] high_edges [4], low_edges [4], h0 [4], l0 [4], d;
    logic [7:0]  low_len [4];
    int          mismatches, total_checks, cycles, hi [4];
    localparam logic [127:0] ADDR_TAB = {8'h5f, 8'h5e, 8'h5b, 8'h5a, 8'h57, 8'h56, 8'h53, 8'h52,
                                         8'h47, 8'h46, 8'h43, 8'h42, 8'h67, 8'h66, 8'h63, 8'h60};
    mpm_core #(.NPH(4), .NCFG(8)) i_mpm_core (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .config_strap(config_strap),
        .address_strap(address_strap), .pulse_insert(pulse_insert), .pwm_high(pwm_high),
        .pwm_low(pwm_low), .bus_address(bus_address));
    mpm_stage_model i_mpm_stage_model (.pclk(pclk), .presetn(presetn), .pwm_high(pwm_high),
        .pwm_low(pwm_low), .high_edges(high_edges), .low_edges(low_edges), .low_len(low_len));
    // Clock and hang guard; the whole run needs about 1200 cycles
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("CHECK FAILED %0t timeout", $time);
            test_done();
        end
    end
    // ****************************************************************
    // Bus and compare helpers
    // ****************************************************************
    // Request held until pready is seen high at an edge, then released
    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, string m);
        apb(1'b0, a, 32'h0);
        chk(rd & mask, exp, m);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        rdchk(`MPM_A_OWNER, 32'hf, 32'hc, "owner reset");
        rdchk(`MPM_A_PERIOD, 32'hffff, 32'h14, "period reset");
        rdchk(`MPM_A_DROPDLY, 32'hffffff, 32'h2710, "drop delay reset");
        rdchk(`MPM_A_REFRESH, 32'hffffff, 32'h3e8, "refresh reset");
        rdchk(`MPM_A_VLIMIT0, 32'hffffffff, 32'hffff0000, "limit reset");
        rdchk(8'h48, 32'hffffffff, 32'h0, "unmapped read");
        chk(err, 1'b1, "unmapped error");
        chk(bus_address, 7'h60, "address at reset");
        $display("test reset done");
    endtask
    task t_addr;
        for (int b = 0; b < 16; b++) begin
            address_strap <= b[3:0];
            repeat (6) @(posedge pclk);
            chk(bus_address, ADDR_TAB[b * 8 +: 7], "strap decode");
        end
        rdchk(`MPM_A_STATUS, 32'h7f0000, {9'h0, ADDR_TAB[120 +: 7], 16'h0}, "status addr");
        $display("test address done");
    endtask
    task t_period;
        apb(1'b1, `MPM_A_PERIOD, 32'h5);
        rdchk(`MPM_A_PERIOD, 32'hffff, 32'd10, "period floor");
        apb(1'b1, `MPM_A_PERIOD, 32'd100);
        rdchk(`MPM_A_PERIOD, 32'hffff, 32'd50, "period ceiling");
        apb(1'b1, `MPM_A_PERIOD, 32'h0003001e);
        apb(1'b1, `MPM_A_PERIOD, 32'h00000014);
        config_strap <= 3'h3;
        repeat (4) @(posedge pclk);
        apb(1'b1, `MPM_A_CTRL, 32'h0);
        rdchk(`MPM_A_PERIOD, 32'hffff, 32'd30, "stored set applied");
        rdchk(`MPM_A_CTRL, 32'h70, 32'h30, "strap readback");
        $display("test period done");
    endtask
    task t_pwm;
        apb(1'b1, `MPM_A_OWNER, 32'h0);
        apb(1'b1, `MPM_A_PERIOD, 32'd20);
        apb(1'b1, `MPM_A_DUTY0, 32'h00080002);
        apb(1'b1, `MPM_A_THRESH, 32'h0);
        apb(1'b1, `MPM_A_CTRL, 32'h1);
        repeat (40) @(posedge pclk);
        hi = '{0, 0, 0, 0};
        repeat (40) begin
            @(posedge pclk);
            for (int j = 0; j < 4; j++) hi[j] += (pwm_high[j] === 1'b1);
        end
        for (int j = 0; j < 4; j++) chk(hi[j], 32'd12, "pulse width");
        h0 = high_edges;
        repeat (200) @(posedge pclk);
        for (int j = 0; j < 4; j++) chk(high_edges[j] - h0[j], 32'd10, "steady rate");
        pulse_insert <= 1'b1;
        h0 = high_edges;
        repeat (200) @(posedge pclk);
        pulse_insert <= 1'b0;
        d = high_edges[3] - h0[3]; // Phase 0 would merge the insert into its own pulse
        chk(d > 10 && d <= 20, 1'b1, "inserted pulses bounded");
        $display("test pwm done");
    endtask
    task t_drop;
        apb(1'b1, `MPM_A_OWNER, 32'h8);
        apb(1'b1, `MPM_A_DROPDLY, 32'd20);
        apb(1'b1, `MPM_A_REFRESH, 32'd100);
        apb(1'b1, `MPM_A_THRESH, 32'h00640064);
        apb(1'b1, `MPM_A_ILOAD1, 32'd1000);
        apb(1'b1, `MPM_A_ILOAD0, 32'd50);
        repeat (60) @(posedge pclk);
        rdchk(`MPM_A_STATUS, 32'hf, 32'hf, "no drop when disabled");
        apb(1'b1, `MPM_A_CTRL, 32'h3);
        repeat (8) @(posedge pclk);
        rdchk(`MPM_A_STATUS, 32'hf, 32'hf, "drop waits for delay");
        repeat (16) @(posedge pclk);
        rdchk(`MPM_A_STATUS, 32'hf, 32'hb, "highest dropped first");
        repeat (20) @(posedge pclk);
        rdchk(`MPM_A_STATUS, 32'hf, 32'h9, "second drop");
        h0 = high_edges;
        l0 = low_edges;
        repeat (250) @(posedge pclk);
        chk(high_edges[2] - h0[2], 32'h0, "dropped phase silent");
        chk(low_len[2], 32'd4, "refresh width");
        d = low_edges[2] - l0[2];
        chk(d >= 2 && d <= 3, 1'b1, "refresh rate");
        apb(1'b1, `MPM_A_ILOAD0, 32'd250);
        repeat (5) @(posedge pclk);
        rdchk(`MPM_A_STATUS, 32'hf, 32'hb, "last dropped returns first");
        apb(1'b1, `MPM_A_ILOAD0, 32'd50);
        repeat (50) @(posedge pclk);
        apb(1'b1, `MPM_A_ERRFAST, 32'h006400c8);
        rdchk(`MPM_A_STATUS, 32'hf, 32'hf, "fast add");
        apb(1'b1, `MPM_A_ERRFAST, 32'h00640000);
        apb(1'b1, `MPM_A_OWNER, 32'hc);
        apb(1'b1, `MPM_A_ILOAD1, 32'd50);
        repeat (30) @(posedge pclk);
        rdchk(`MPM_A_STATUS, 32'hc, 32'h8, "output 1 drops lowest");
        apb(1'b1, `MPM_A_CTRL, 32'h0);
        $display("test drop done");
    endtask
    task t_vout;
        // Bounds kept ordered with max above min, as a host must
        apb(1'b1, `MPM_A_VLIMIT0, 32'h10000100);
        apb(1'b1, `MPM_A_VREQ, 32'h00000800);
        rdchk(`MPM_A_VTARGET, 32'hffff, 32'h0800, "setpoint");
        apb(1'b1, `MPM_A_VREQ, 32'h00002000);
        rdchk(`MPM_A_VTARGET, 32'hffff, 32'h1000, "clamp max");
        apb(1'b1, `MPM_A_VREQ, 32'h00080010);
        rdchk(`MPM_A_VTARGET, 32'hffff, 32'h0100, "fast path clamp min");
        apb(1'b1, `MPM_A_VREQ, 32'h00020fff);
        rdchk(`MPM_A_VTARGET, 32'hffff, 32'h0100, "margin leaves setpoint");
        apb(1'b1, `MPM_A_VREQ, 32'h00011234);
        rdchk(`MPM_A_VTARGET, 32'hffffffff, 32'h12340100, "second output");
        apb(1'b1, `MPM_A_VTARGET, 32'h0);
        rdchk(`MPM_A_VTARGET, 32'hffffffff, 32'h12340100, "target read only");
        apb(1'b1, `MPM_A_ILOAD0, 32'd1000);
        apb(1'b1, `MPM_A_TEMPCOMP, 32'h8000);
        rdchk(`MPM_A_ICORR, 32'hffff, 32'd1500, "current correction");
        $display("test vout done");
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {psel, penable, pwrite, pulse_insert, presetn} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        config_strap = 3'h0;
        address_strap = 4'h0;
        {mismatches, total_checks, cycles} = {32'd0, 32'd0, 32'd0};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_addr;
        t_period;
        t_pwm;
        t_drop;
        t_vout;
        test_done;
    end
endmodule

// [tb/mpm_stage_model.sv]
// Behavioural per-phase power stage: counts turn-ons and times low-side pulses
`timescale 1ns/1ps
module mpm_stage_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  pwm_high,
    input  wire logic [3:0]  pwm_low,
    output logic      [15:0] high_edges [4],
    output logic      [15:0] low_edges [4],
    output logic      [7:0]  low_len [4]
);
    logic [3:0] last_high, last_low;
    logic [7:0] run [4];
    // Width is latched when the pulse ends, so a pulse in flight is never reported
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_high <= 4'h0;
            last_low <= 4'h0;
            for (int j = 0; j < 4; j++) begin
                high_edges[j] <= 16'h0;
                low_edges[j] <= 16'h0;
                low_len[j] <= 8'h0;
                run[j] <= 8'h0;
            end
        end else begin
            last_high <= pwm_high;
            last_low <= pwm_low;
            for (int j = 0; j < 4; j++) begin
                if (pwm_high[j] && !last_high[j]) high_edges[j] <= high_edges[j] + 16'h1;
                if (pwm_low[j] && !last_low[j]) low_edges[j] <= low_edges[j] + 16'h1;
                run[j] <= pwm_low[j] ? run[j] + 8'h1 : 8'h0;
                if (!pwm_low[j] && last_low[j]) low_len[j] <= run[j];
            end
        end
    end
endmodule
